// ==== dv/drive_run_stop_command_arbiter_tb.sv ====
// Self-checking bench for the run and stop command arbiter
`timescale 1ns/100ps
module drive_run_stop_command_arbiter_tb
   import drs_pkg::*;
;
   logic clk, rstn, psel, pen, pwr, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, v, fq;
   logic forward_run, reverse_run, dir, dcb, err, seen;
   logic [3:0] step;
   logic [2:0] keys;
   logic [7:0] term;
   logic kst, krun, kprg, kdir;
   logic run_f, run_r, sreq, sled, prog, seq;
   logic [1:0] smeth, aout;
   logic [15:0] freq, btime;
   integer errors, checks, seed;

   drs_arbiter #(.SCAN_DIV(4)) i_dut (.i_sys_clk(clk), .i_resetn(rstn),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_term(term), .i_key_stop(kst),
      .i_key_run(krun), .i_key_dir_rev(kdir), .i_key_program_mode(kprg),
      .i_dc_brake_cmd(dcb), .i_out_freq(freq), .o_run_fwd(run_f),
      .o_run_rev(run_r), .o_stop_req(sreq), .o_stop_method(smeth),
      .o_stop_led(sled), .o_program_mode(prog), .o_seq_led(seq),
      .o_aout_sel(aout), .o_dc_brake_time(btime));

   drs_panel_model i_panel (.i_sys_clk(clk), .i_resetn(rstn), .i_fwd(forward_run),
      .i_rev(reverse_run), .i_step(step), .i_keys(keys), .i_dir_rev(dir),
      .o_term(term), .o_key_stop(kst), .o_key_run(krun),
      .o_key_program_mode(kprg), .o_key_dir_rev(kdir));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic results();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Waits for pready with no assumed latency
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      // Idle edge so a following call never re-drives psel in this step
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic press(input int k);
      keys[k] <= 1'b1;
      @(posedge clk);
      keys <= 3'h0;
      cyc(6);
   endtask

   // Notes whether run (led=0) or stop lamp (led=1) goes high
   task automatic watch(input int n, input logic led);
      seen = 1'b0;
      repeat (n)
      begin
         @(posedge clk);
         seen = seen | ((led ? sled : run_f) === 1'b1);
      end
   endtask

   // Four-cycle pulse spans exactly one scan tick
   task automatic pulse();
      forward_run <= 1'b1;
      cyc(4);
      forward_run <= 1'b0;
      watch(20, 1'b0);
   endtask

   initial
   begin
      #200000;
      errors = errors + 1;
      results();
   end

   initial
   begin
      errors = 0;
      checks = 0;
      seed = 32'hB7CE;
      rstn = 1'b0;
      {psel, pen, pwr, forward_run, reverse_run, dir, dcb} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      step = 4'h0;
      keys = 3'h0;
      freq = 16'h0000;
      cyc(3);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(OFS_IO_FUNC, 32'h0);
      rdc(OFS_RUN_STOP, 32'h0);
      rdc(OFS_AUX, 32'h0);
      rdc(OFS_LOCK_TIME, {16'h0000, LOCK_TIME_RST});
      rdc(OFS_STATUS, 32'h0);
      v = $random(seed) & 32'hF;
      apb(1'b1, OFS_IO_FUNC, v);
      rdc(OFS_IO_FUNC, v);
      rdc(8'h18, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, OFS_IO_FUNC, i[1] << 3);
         apb(1'b1, OFS_AUX, i[0]);
         cyc(3);
         chk(aout, i[1:0]);
         apb(1'b1, OFS_AUX, 2 | i[0]);
         cyc(3);
         chk(aout, {1'b0, i[0]});
         apb(1'b1, OFS_RUN_STOP, i << 2);
         cyc(3);
         chk(smeth, i[1:0]);
      end
      apb(1'b1, OFS_AUX, 32'h0);
      apb(1'b1, OFS_RUN_STOP, 32'h0);
      apb(1'b1, OFS_IO_FUNC, 32'h1);
      forward_run <= 1'b1;
      cyc(30);
      chk(run_f, 1'b1);
      chk(seq, 1'b1);
      press(0);
      cyc(24);
      chk(run_f, 1'b1);
      apb(1'b1, OFS_IO_FUNC, 32'h0);
      press(0);
      chk(sreq, 1'b1);
      cyc(24);
      chk(run_f, 1'b0);
      // Lamp toggles every 256 ticks; 2100 cycles span a lit half
      watch(2100, 1'b1);
      chk(seen, 1'b1);
      v = $random(seed);
      step <= v[3:0] | 4'h1;
      cyc(30);
      chk(run_f, 1'b1);
      chk(sled, 1'b0);
      press(0);
      forward_run <= 1'b0;
      cyc(30);
      forward_run <= 1'b1;
      cyc(30);
      chk(run_f, 1'b1);
      forward_run <= 1'b0;
      apb(1'b1, OFS_IO_FUNC, 32'h2);
      reverse_run <= 1'b1;
      cyc(30);
      chk(run_r, 1'b0);
      apb(1'b1, OFS_IO_FUNC, 32'h0);
      cyc(30);
      chk(run_r, 1'b1);
      reverse_run <= 1'b0;
      forward_run <= 1'b1;
      apb(1'b1, OFS_RUN_STOP, 32'h2);
      cyc(30);
      chk(run_f, 1'b0);
      chk(seq, 1'b0);
      press(1);
      chk(run_f, 1'b1);
      press(0);
      forward_run <= 1'b0;
      dir <= 1'b1;
      apb(1'b1, OFS_IO_FUNC, 32'h2);
      press(1);
      chk(run_r, 1'b0);
      apb(1'b1, OFS_IO_FUNC, 32'h0);
      press(1);
      chk(run_r, 1'b1);
      press(2);
      chk(prog, 1'b0);
      press(0);
      dcb <= 1'b1;
      cyc(30);
      press(2);
      chk(prog, 1'b0);
      dcb <= 1'b0;
      press(2);
      chk(prog, 1'b1);
      press(2);
      chk(prog, 1'b0);
      apb(1'b1, OFS_RUN_STOP, 32'h8);
      forward_run <= 1'b1;
      cyc(30);
      fq = $random(seed);
      freq <= fq[15:0];
      cyc(2);
      forward_run <= 1'b0;
      cyc(30);
      chk(btime, fq[15:0]);
      rdc(OFS_BRAKE, {16'h0000, fq[15:0]});
      apb(1'b1, OFS_LOCK_TIME, 32'h8);
      apb(1'b1, OFS_RUN_STOP, 32'hC);
      forward_run <= 1'b1;
      cyc(30);
      forward_run <= 1'b0;
      cyc(14);
      forward_run <= 1'b1;
      cyc(12);
      chk(run_f, 1'b0);
      chk(sreq, 1'b1);
      cyc(60);
      chk(run_f, 1'b1);
      forward_run <= 1'b0;
      apb(1'b1, OFS_RUN_STOP, 32'h0);
      cyc(30);
      pulse();
      chk(seen, 1'b0);
      apb(1'b1, OFS_IO_FUNC, 32'h4);
      pulse();
      chk(seen, 1'b1);
      results();
   end
endmodule

// ==== dv/drs_panel_model.sv ====
// Keypad and control terminal model driving the arbiter inputs
`timescale 1ns/100ps
module drs_panel_model
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_fwd,
   input wire logic i_rev,
   input wire logic [3:0] i_step,
   input wire logic [2:0] i_keys,
   input wire logic i_dir_rev,
   output logic [7:0] o_term,
   output logic o_key_stop,
   output logic o_key_run,
   output logic o_key_program_mode,
   output logic o_key_dir_rev
);
   // Fault and reset terminals stay open; not part of this block
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_term <= 8'h00;
         o_key_stop <= 1'b0;
         o_key_run <= 1'b0;
         o_key_program_mode <= 1'b0;
         o_key_dir_rev <= 1'b0;
      end
      else
      begin
         o_term <= {i_step, 2'b00, i_rev, i_fwd};
         // One-cycle key pulses: a held program key would toggle
         o_key_stop <= i_keys[0];
         o_key_run <= i_keys[1];
         o_key_program_mode <= i_keys[2];
         o_key_dir_rev <= i_dir_rev;
      end
   end
endmodule

// ==== hdl/drs_arbiter.sv ====
// Run and stop command arbiter with APB register access
`timescale 1ns/100ps
module drs_arbiter
   import drs_pkg::*;
#(
   parameter int unsigned SCAN_DIV = SCAN_CYCLES
)
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [TERM_COUNT-1:0] i_term,
   input wire logic i_key_stop,
   input wire logic i_key_run,
   input wire logic i_key_dir_rev,
   input wire logic i_key_program_mode,
   input wire logic i_dc_brake_cmd,
   input wire logic [15:0] i_out_freq,
   output logic o_run_fwd,
   output logic o_run_rev,
   output logic o_stop_req,
   output logic [1:0] o_stop_method,
   output logic o_stop_led,
   output logic o_program_mode,
   output logic o_seq_led,
   output logic [1:0] o_aout_sel,
   output logic [15:0] o_dc_brake_time
);
   localparam int unsigned DIV_W = $clog2(SCAN_DIV + 1);

   logic [3:0] io_func;
   logic [3:0] run_stop;
   logic [1:0] aux_sel;
   logic [15:0] lock_time;
   logic [DIV_W-1:0] div_cnt;
   logic scan_tick;
   logic [BLINK_BIT:0] blink_cnt;
   logic [TERM_COUNT-1:0] term;
   logic [3:0] step_prev;
   logic stop_latch;
   logic key_run;
   logic lock_busy;
   drs_state_t state;
   drs_state_t next_state;
   drs_stop_t method;
   logic src_term;
   logic t_fwd;
   logic t_rev;
   logic run_req;
   logic dir_rev;
   logic run_ok;
   logic stopped;
   logic step_change;
   logic key_stop_take;
   logic lock_start;
   logic apb_setup;
   logic apb_write;
   logic addr_ok;
   logic [31:0] rd_word;

   generate
      if (SCAN_DIV < 2)
      begin : g_chk
         $error("SCAN_DIV must be at least 2");
      end
   endgenerate

   // Register access over APB
   assign apb_setup = i_psel && !i_penable;
   assign apb_write = i_psel && i_penable && o_pready && i_pwrite;

   always_comb
   begin
      addr_ok = 1'b1;
      rd_word = 32'h0000_0000;
      case (i_paddr)
         OFS_IO_FUNC: rd_word[3:0] = io_func;
         OFS_RUN_STOP: rd_word[3:0] = run_stop;
         OFS_AUX: rd_word[1:0] = aux_sel;
         OFS_LOCK_TIME: rd_word[15:0] = lock_time;
         OFS_STATUS: rd_word[9:0] = {lock_busy, stop_latch, o_program_mode,
            o_aout_sel, o_stop_method, 1'b0, state};
         OFS_BRAKE: rd_word[15:0] = o_dc_brake_time;
         default: addr_ok = 1'b0;
      endcase
   end

   // Answer in the first access cycle, no wait states
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         o_pready <= apb_setup;
         o_pslverr <= apb_setup && !addr_ok;
         o_prdata <= (apb_setup && !i_pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Writes apply at once, even mid-run; software must stop first
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         io_func <= IO_FUNC_RST;
         run_stop <= RUN_STOP_RST;
         aux_sel <= AUX_RST;
         lock_time <= LOCK_TIME_RST;
      end
      else if (apb_write)
      begin
         case (i_paddr)
            OFS_IO_FUNC: io_func <= i_pwdata[3:0];
            OFS_RUN_STOP: run_stop <= i_pwdata[3:0];
            OFS_AUX: aux_sel <= i_pwdata[1:0];
            OFS_LOCK_TIME: lock_time <= i_pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Scan rate divider
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         div_cnt <= '0;
         scan_tick <= 1'b0;
      end
      else
      begin
         scan_tick <= (div_cnt == DIV_W'(SCAN_DIV - 1));
         if (div_cnt == DIV_W'(SCAN_DIV - 1))
            div_cnt <= '0;
         else
            div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         blink_cnt <= '0;
      else if (scan_tick)
         blink_cnt <= blink_cnt + 1'b1;
   end

   drs_scan #(
      .WIDTH(TERM_COUNT)
   ) u_scan (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_tick(scan_tick),
      .i_single(io_func[IO_SINGLE_SCAN]),
      .i_raw(i_term),
      .o_state(term)
   );

   drs_lockout u_lock (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_start(lock_start),
      .i_tick(scan_tick),
      .i_len(lock_time),
      .o_busy(lock_busy)
   );

   // Command decode
   assign method = drs_stop_t'(run_stop[RS_METHOD_LO +: 2]);
   assign src_term = !run_stop[RS_RUN_SRC];
   assign t_fwd = src_term && term[TERM_FWD];
   assign t_rev = src_term && term[TERM_REV];
   assign run_req = src_term ? (t_fwd || t_rev) : key_run;
   assign dir_rev = src_term ? (t_rev && !t_fwd) : i_key_dir_rev;
   assign run_ok = run_req && !stop_latch && !o_program_mode
      && !(dir_rev && io_func[IO_REV_PROHIBIT]);
   assign stopped = !term[TERM_FWD] && !term[TERM_REV]
      && !i_dc_brake_cmd && (state == ST_IDLE);
   assign step_change = term[TERM_STEP_LO +: 4] != step_prev;
   assign key_stop_take = i_key_stop && src_term && (state == ST_RUN)
      && !io_func[IO_STOP_IGNORE];
   assign lock_start = (state == ST_RUN) && !run_ok
      && (method == SM_COAST_TIMED);

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         step_prev <= 4'h0;
      else
         step_prev <= term[TERM_STEP_LO +: 4];
   end

   // Set wins over release so a press in the release cycle holds
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         stop_latch <= 1'b0;
      else if (key_stop_take)
         stop_latch <= 1'b1;
      else if ((!term[TERM_FWD] && !term[TERM_REV]) || step_change
         || !src_term)
         stop_latch <= 1'b0;
   end

   // Keypad run is a held request ended by the keypad stop key
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         key_run <= 1'b0;
      else if (src_term || i_key_stop)
         key_run <= 1'b0;
      else if (i_key_run && !o_program_mode)
         key_run <= 1'b1;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_program_mode <= 1'b0;
      else if (i_key_program_mode && stopped)
         o_program_mode <= !o_program_mode;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (run_ok)
               next_state = ST_RUN;
         ST_RUN:
            if (!run_ok)
               next_state = lock_start ? ST_LOCK : ST_STOP;
         ST_STOP:
            if (!stop_latch)
               next_state = ST_IDLE;
         ST_LOCK:
            // Timer is one cycle behind the start, so wait past it
            if (!lock_busy && !lock_start)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Drive outputs
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_run_fwd <= 1'b0;
         o_run_rev <= 1'b0;
         o_stop_req <= 1'b0;
         o_stop_method <= SM_RAMP;
         o_stop_led <= 1'b0;
         o_seq_led <= 1'b0;
      end
      else
      begin
         o_run_fwd <= (next_state == ST_RUN) && !dir_rev;
         o_run_rev <= (next_state == ST_RUN) && dir_rev;
         o_stop_req <= (next_state == ST_STOP) || (next_state == ST_LOCK);
         o_stop_method <= method;
         o_stop_led <= stop_latch && blink_cnt[BLINK_BIT];
         o_seq_led <= src_term;
      end
   end

   // Brake length follows the frequency caught at the stop edge
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_dc_brake_time <= 16'h0000;
      else if ((state == ST_RUN) && !run_ok && (method == SM_DC_BRAKE))
         o_dc_brake_time <= i_out_freq;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_aout_sel <= 2'b00;
      else
         o_aout_sel <= {io_func[IO_AOUT_DIGIT] && !aux_sel[AUX_ENCODER],
            aux_sel[AUX_AOUT_BIT]};
   end

   stop_accept_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      key_stop_take |=> stop_latch ##1 o_stop_req)
      else $error("accepted keypad stop not latched");

   stop_ignore_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_key_stop && src_term && io_func[IO_STOP_IGNORE] && !stop_latch)
      |=> !stop_latch)
      else $error("keypad stop taken while ignored");

   stop_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (stop_latch && src_term && (term[TERM_FWD] || term[TERM_REV])
      && !step_change) |=> stop_latch)
      else $error("stop latch released early");

   rev_reject_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (io_func[IO_REV_PROHIBIT] && dir_rev) |=> !o_run_rev)
      else $error("reverse run while prohibited");

   key_source_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (!src_term && !key_run && (state == ST_IDLE)) |=> (state != ST_RUN))
      else $error("terminal run taken from keypad source");

   program_mode_stopped_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_key_program_mode && !stopped) |=> $stable(o_program_mode))
      else $error("program key acted while running");

   lock_norun_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      lock_start |=> (!o_run_fwd && !o_run_rev) [*2])
      else $error("run during lockout");

   brake_catch_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      ((state == ST_RUN) && !run_ok && (method == SM_DC_BRAKE))
      |=> (o_dc_brake_time == $past(i_out_freq)))
      else $error("brake time not taken from frequency");

   aout_encoder_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      aux_sel[AUX_ENCODER] |=> !o_aout_sel[1])
      else $error("analog digit used in encoder mode");

   apb_answer_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      apb_setup |=> o_pready)
      else $error("APB access not answered");
endmodule

// ==== hdl/drs_lockout.sv ====
// Run lockout timer for the timed coast stop
`timescale 1ns/100ps
module drs_lockout
   import drs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic i_tick,
   input wire logic [15:0] i_len,
   output logic o_busy
);
   logic [15:0] remain;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         remain <= 16'h0000;
      else if (i_start)
         remain <= i_len;
      else if (i_tick && (remain != 16'h0000))
         remain <= remain - 16'h0001;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_busy <= 1'b0;
      else
         o_busy <= i_start ? (i_len != 16'h0000) : (remain != 16'h0000);
   end

   lock_start_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_start && (i_len > 16'h0001)) |=> ##1 o_busy)
      else $error("lockout did not start");
endmodule

// ==== hdl/drs_pkg.sv ====
// Constants and types shared by the run and stop command arbiter
package drs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SCAN_PERIOD_NS = 1000000;
   localparam int unsigned SCAN_CYCLES =
      (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TERM_COUNT = 8;
   localparam int unsigned BLINK_BIT = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_IO_FUNC = 8'h00;
   localparam logic [7:0] OFS_RUN_STOP = 8'h04;
   localparam logic [7:0] OFS_AUX = 8'h08;
   localparam logic [7:0] OFS_LOCK_TIME = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_BRAKE = 8'h14;
   // io_terminal_function_setting fields
   localparam int unsigned IO_STOP_IGNORE = 0;
   localparam int unsigned IO_REV_PROHIBIT = 1;
   localparam int unsigned IO_SINGLE_SCAN = 2;
   localparam int unsigned IO_AOUT_DIGIT = 3;
   // run_source_stop_method_param fields
   localparam int unsigned RS_FREQ_SRC = 0;
   localparam int unsigned RS_RUN_SRC = 1;
   localparam int unsigned RS_METHOD_LO = 2;
   // aux_selection_param fields
   localparam int unsigned AUX_AOUT_BIT = 0;
   localparam int unsigned AUX_ENCODER = 1;
   // Terminal positions within the scanned word
   localparam int unsigned TERM_FWD = 0;
   localparam int unsigned TERM_REV = 1;
   localparam int unsigned TERM_STEP_LO = 4;
   // Reset values
   localparam logic [3:0] IO_FUNC_RST = 4'h0;
   localparam logic [3:0] RUN_STOP_RST = 4'h0;
   localparam logic [1:0] AUX_RST = 2'h0;
   localparam logic [15:0] LOCK_TIME_RST = 16'h0064;
   typedef enum logic [1:0] {
      SM_RAMP = 2'b00,
      SM_COAST = 2'b01,
      SM_DC_BRAKE = 2'b10,
      SM_COAST_TIMED = 2'b11
   } drs_stop_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_STOP = 2'b11,
      ST_LOCK = 2'b10
   } drs_state_t;
endpackage

// ==== hdl/drs_scan.sv ====
// Sequence input sampler with single or double scanning
`timescale 1ns/100ps
module drs_scan
   import drs_pkg::*;
#(
   parameter int unsigned WIDTH = TERM_COUNT
)
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_tick,
   input wire logic i_single,
   input wire logic [WIDTH-1:0] i_raw,
   output logic [WIDTH-1:0] o_state
);
   logic [WIDTH-1:0] prev;

   generate
      if (WIDTH < 1)
      begin : g_chk
         $error("drs_scan needs at least one input");
      end
      for (genvar b = 0; b < WIDTH; b++)
      begin : g_bit
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               prev[b] <= 1'b0;
               o_state[b] <= 1'b0;
            end
            else if (i_tick)
            begin
               prev[b] <= i_raw[b];
               // Two agreeing samples filter contact bounce
               if (i_single || (i_raw[b] == prev[b]))
                  o_state[b] <= i_raw[b];
            end
         end
      end
   endgenerate

   double_agree_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_tick && !i_single)
      |=> (((o_state ^ $past(o_state)) & $past(i_raw ^ prev)) == '0))
      else $error("double scan took an unconfirmed sample");
endmodule
